// file: hw/vectored_interrupt_pair.sv
module vectored_interrupt_pair (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] setup_switch_bank_i,
  input wire logic [7:0] port_addr_i,
  input wire logic [7:0] port_data_i,
  input wire logic port_rd_i,
  input wire logic port_wr_i,
  input wire logic acknowledge_pulse_i,
  input wire logic [7:0] vectored_line_i,
  input wire logic timer_output_two_i,
  input wire logic timer_output_three_i,
  input wire logic timer_output_four_i,
  input wire logic serial_receive_ready_flag_i,
  input wire logic parallel_receive_ready_flag_i,
  input wire logic serial_transmit_ready_flag_i,
  input wire logic parallel_transmit_ready_flag_i,
  output logic [7:0] port_data_o,
  output logic port_data_oe_o,
  output logic int_req_o
);

  typedef struct packed {
    logic [3:0] sw_s1;
    logic [3:0] sw_s2;
    logic [15:0] req_s1;
    logic [15:0] req_s2;
    logic [7:0] adr_s1;
    logic [7:0] adr_s2;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic rd_s1;
    logic rd_s2;
    logic wr_s1;
    logic wr_s2;
    logic wr_d;
    logic ack_s1;
    logic ack_s2;
    logic ack_d;
    logic [1:0][7:0] request_latch;
    logic [1:0][7:0] in_service_latch;
    logic [1:0][7:0] mask;
    logic [1:0][2:0] top;
    logic [1:0][2:0] port_window_origin_lo;
    logic [1:0][7:0] port_window_origin_hi;
    logic [1:0] intv4;
    logic [1:0] two_pulse;
    logic [1:0] auto_eos;
    logic [1:0] read_isr;
    vectored_interrupt_pair_pkg::setup_e [1:0] setup;
    logic [1:0] ack_cnt;
    logic ack_valid;
    logic use_sec;
    logic [2:0] lvl_p;
    logic [2:0] lvl_s;
    logic [7:0] dout;
    logic oe;
    logic int_o;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Walks the eight levels from the top one; an in-service level stops the walk
  function automatic logic [3:0] find_top(input logic [7:0] req, input logic [7:0] busy,
                                         input logic [2:0] top);
    logic [3:0] res;
    logic done;
    logic [2:0] l;
    res = 4'h0;
    done = 1'b0;
    for (int i = 0; i < 8; i++) begin
      l = top + 3'(i);
      if (!done && busy[l]) begin
        done = 1'b1;
      end else if (!done && req[l]) begin
        done = 1'b1;
        res = {1'b1, l};
      end
    end
    return res;
  endfunction : find_top

  logic [1:0] res_ok;
  logic [1:0][2:0] res_lvl;
  logic [1:0] eos_ok;
  logic [1:0][2:0] eos_lvl;

  for (genvar c = 0; c < 2; c++) begin : g_ctl
    assign {res_ok[c], res_lvl[c]} = find_top(st_r.request_latch[c] & ~st_r.mask[c],
                                              st_r.in_service_latch[c], st_r.top[c]);
    assign {eos_ok[c], eos_lvl[c]} = find_top(st_r.in_service_latch[c], 8'h00,
                                              st_r.top[c]);
  end

  logic win_hit;
  logic ctl_hit;
  logic sel;
  logic wr_hit;
  logic rd_hit;
  logic ack_rise;
  logic ack_fall;
  logic [1:0] last_pulse;
  logic [2:0] ack_lvl;

  assign win_hit = st_r.adr_s2[7:4] == st_r.sw_s2;
  assign sel = st_r.adr_s2[1];
  assign ack_rise = st_r.ack_s2 && !st_r.ack_d;
  assign ack_fall = !st_r.ack_s2 && st_r.ack_d;
  assign ack_lvl = st_r.use_sec ? st_r.lvl_s : st_r.lvl_p;
  assign last_pulse = st_r.two_pulse[0] ? vectored_interrupt_pair_pkg::PULSE_SECOND
                                        : vectored_interrupt_pair_pkg::PULSE_THIRD;

  always_comb begin
    if (!win_hit) begin
      ctl_hit = 1'b0;
    end else if (st_r.adr_s2[3:1] == vectored_interrupt_pair_pkg::PORT_PRIMARY) begin
      ctl_hit = 1'b1;
    end else if (st_r.adr_s2[3:1] == vectored_interrupt_pair_pkg::PORT_SECONDARY) begin
      ctl_hit = 1'b1;
    end else begin
      ctl_hit = 1'b0;
    end
  end

  assign wr_hit = ctl_hit && st_r.wr_s2 && !st_r.wr_d;
  assign rd_hit = ctl_hit && st_r.rd_s2;

  always_comb begin
    logic vsel;
    logic [2:0] vl;
    logic [15:0] addr16;
    logic [7:0] d;
    vsel = st_r.use_sec;
    vl = st_r.use_sec ? st_r.lvl_s : st_r.lvl_p;
    d = st_r.dat_s2;
    addr16 = 16'h0000;
    st_nxt = st_r;
    // Pins cross two flops before anything reads them
    st_nxt.sw_s1 = setup_switch_bank_i;
    st_nxt.sw_s2 = st_r.sw_s1;
    st_nxt.req_s1 = {timer_output_four_i, parallel_transmit_ready_flag_i,
                     serial_transmit_ready_flag_i, timer_output_three_i, vectored_line_i[1],
                     parallel_receive_ready_flag_i, serial_receive_ready_flag_i,
                     timer_output_two_i, vectored_line_i[7:2], 1'b0, vectored_line_i[0]};
    st_nxt.req_s2 = st_r.req_s1;
    st_nxt.adr_s1 = port_addr_i;
    st_nxt.adr_s2 = st_r.adr_s1;
    st_nxt.dat_s1 = port_data_i;
    st_nxt.dat_s2 = st_r.dat_s1;
    st_nxt.rd_s1 = port_rd_i;
    st_nxt.rd_s2 = st_r.rd_s1;
    st_nxt.wr_s1 = port_wr_i;
    st_nxt.wr_s2 = st_r.wr_s1;
    st_nxt.wr_d = st_r.wr_s2;
    st_nxt.ack_s1 = acknowledge_pulse_i;
    st_nxt.ack_s2 = st_r.ack_s1;
    st_nxt.ack_d = st_r.ack_s2;
    // Secondary's own request result stands in for primary input one
    st_nxt.request_latch[0] = {st_r.req_s2[7:2], res_ok[1], st_r.req_s2[0]};
    st_nxt.request_latch[1] = st_r.req_s2[15:8];

    if (wr_hit && !st_r.adr_s2[0]) begin
      if (d[vectored_interrupt_pair_pkg::INIT_FLAG_BIT]) begin
        st_nxt.setup[sel] = vectored_interrupt_pair_pkg::SETUP_ADDR;
        st_nxt.port_window_origin_lo[sel] = d[7:5];
        st_nxt.intv4[sel] = d[vectored_interrupt_pair_pkg::INTERVAL4_BIT];
        st_nxt.top[sel] = vectored_interrupt_pair_pkg::TOP_LEVEL_AFTER_INIT;
        st_nxt.mask[sel] = vectored_interrupt_pair_pkg::BYTE_RESET;
        st_nxt.in_service_latch[sel] = vectored_interrupt_pair_pkg::BYTE_RESET;
        st_nxt.two_pulse[sel] = 1'b0;
        st_nxt.auto_eos[sel] = 1'b0;
        st_nxt.read_isr[sel] = 1'b0;
      end else if (d[vectored_interrupt_pair_pkg::READ_SEL_BIT]) begin
        st_nxt.read_isr[sel] = d[0];
      end else if (d[7:5] == vectored_interrupt_pair_pkg::CMD_NONSPECIFIC) begin
        if (eos_ok[sel]) begin
          st_nxt.in_service_latch[sel][eos_lvl[sel]] = 1'b0;
        end
      end else if (d[7:5] == vectored_interrupt_pair_pkg::CMD_SPECIFIC) begin
        st_nxt.in_service_latch[sel][d[2:0]] = 1'b0;
      end else if (d[7:5] == vectored_interrupt_pair_pkg::CMD_SET_TOP) begin
        st_nxt.top[sel] = d[2:0];
      end
    end else if (wr_hit) begin
      case (st_r.setup[sel])
        vectored_interrupt_pair_pkg::SETUP_ADDR: begin
          st_nxt.port_window_origin_hi[sel] = d;
          st_nxt.setup[sel] = vectored_interrupt_pair_pkg::SETUP_MODE;
        end
        vectored_interrupt_pair_pkg::SETUP_MODE: begin
          st_nxt.two_pulse[sel] = d[vectored_interrupt_pair_pkg::TWO_PULSE_BIT];
          st_nxt.auto_eos[sel] = d[vectored_interrupt_pair_pkg::AUTO_EOS_BIT];
          st_nxt.setup[sel] = vectored_interrupt_pair_pkg::SETUP_DONE;
        end
        default: begin
          st_nxt.mask[sel] = d;
        end
      endcase
    end

    // Acknowledge handling follows the writes so that a set beats a same-cycle clear
    if (ack_rise) begin
      if (st_r.ack_cnt != vectored_interrupt_pair_pkg::PULSE_THIRD) begin
        st_nxt.ack_cnt = st_r.ack_cnt + 2'h1;
      end
      if (st_r.ack_cnt == vectored_interrupt_pair_pkg::COUNT_RESET) begin
        st_nxt.ack_valid = res_ok[0];
        st_nxt.lvl_p = res_lvl[0];
        st_nxt.lvl_s = res_lvl[1];
        st_nxt.use_sec = res_ok[0] && res_lvl[0] == 3'h1 && res_ok[1];
        if (res_ok[0]) begin
          st_nxt.in_service_latch[0][res_lvl[0]] = 1'b1;
        end
        if (res_ok[0] && res_lvl[0] == 3'h1 && res_ok[1]) begin
          st_nxt.in_service_latch[1][res_lvl[1]] = 1'b1;
        end
      end
    end else if (ack_fall && st_r.ack_cnt >= last_pulse) begin
      st_nxt.ack_cnt = vectored_interrupt_pair_pkg::COUNT_RESET;
      if (st_r.ack_valid && st_r.auto_eos[0] && eos_ok[0]) begin
        st_nxt.in_service_latch[0][eos_lvl[0]] = 1'b0;
      end
      if (st_r.use_sec && st_r.auto_eos[1] && eos_ok[1]) begin
        st_nxt.in_service_latch[1][eos_lvl[1]] = 1'b0;
      end
    end

    if (st_r.intv4[vsel]) begin
      addr16 = {st_r.port_window_origin_hi[vsel], st_r.port_window_origin_lo[vsel], vl, 2'h0};
    end else begin
      addr16 = {st_r.port_window_origin_hi[vsel], st_r.port_window_origin_lo[vsel][2:1], vl, 3'h0};
    end

    st_nxt.oe = 1'b0;
    st_nxt.dout = vectored_interrupt_pair_pkg::BYTE_RESET;
    if (st_r.ack_s2) begin
      // An acknowledge with nothing resolved leaves the bus alone
      if (st_r.ack_valid) begin
        case (st_r.ack_cnt)
          vectored_interrupt_pair_pkg::PULSE_FIRST: begin
            if (!st_r.two_pulse[0]) begin
              st_nxt.oe = 1'b1;
              st_nxt.dout = vectored_interrupt_pair_pkg::CALL_OPCODE;
            end
          end
          vectored_interrupt_pair_pkg::PULSE_SECOND: begin
            st_nxt.oe = 1'b1;
            if (st_r.two_pulse[0]) begin
              st_nxt.dout = {st_r.port_window_origin_hi[vsel][7:3], vl};
            end else begin
              st_nxt.dout = addr16[7:0];
            end
          end
          vectored_interrupt_pair_pkg::PULSE_THIRD: begin
            if (!st_r.two_pulse[0]) begin
              st_nxt.oe = 1'b1;
              st_nxt.dout = addr16[15:8];
            end
          end
          default: begin
            st_nxt.oe = 1'b0;
          end
        endcase
      end
    end else if (rd_hit) begin
      st_nxt.oe = 1'b1;
      if (st_r.adr_s2[0]) begin
        st_nxt.dout = st_r.mask[sel];
      end else if (st_r.read_isr[sel]) begin
        st_nxt.dout = st_r.in_service_latch[sel];
      end else begin
        st_nxt.dout = st_r.request_latch[sel];
      end
    end

    // Line drops while a sequence runs so the host sees one request per sequence
    st_nxt.int_o = res_ok[0] && st_r.ack_cnt == vectored_interrupt_pair_pkg::COUNT_RESET;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.setup <= {vectored_interrupt_pair_pkg::SETUP_DONE,
                     vectored_interrupt_pair_pkg::SETUP_DONE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign port_data_o = st_r.dout;
  assign port_data_oe_o = st_r.oe;
  assign int_req_o = st_r.int_o;

  chk_int_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !res_ok[0] |=> !int_req_o)
    else $error("interrupt line raised with nothing pending");

  chk_call_opcode: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.ack_s2 && st_r.ack_valid && st_r.ack_cnt == 2'h1 && !st_r.two_pulse[0]
    |=> port_data_oe_o && port_data_o == 8'hcd)
    else $error("call opcode missing on first acknowledge");

  chk_two_pulse_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.ack_s2 && st_r.ack_cnt == 2'h1 && st_r.two_pulse[0] |=> !port_data_oe_o)
    else $error("bus driven on first pulse in two-pulse mode");

  chk_no_req_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.ack_s2 && !st_r.ack_valid |=> !port_data_oe_o)
    else $error("bus driven on acknowledge with nothing resolved");

  chk_isr_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_rise && st_r.ack_cnt == 2'h0 && res_ok[0]
    |=> st_r.in_service_latch[0][$past(res_lvl[0])] && st_r.ack_valid)
    else $error("in-service bit not set on acknowledge");

  chk_window_miss: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.wr_s2 && !st_r.wr_d && st_r.adr_s2[7:4] != st_r.sw_s2 |=> $stable(st_r.mask))
    else $error("write outside the port window changed a mask");

  chk_ns_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit && !sel && !st_r.adr_s2[0] && st_r.dat_s2 == 8'h20 && eos_ok[0] && !ack_rise
    |=> !st_r.in_service_latch[0][$past(eos_lvl[0])])
    else $error("non-specific end of service missed the top bit");

  chk_type_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.ack_s2 && st_r.ack_valid && st_r.ack_cnt == 2'h2 && st_r.two_pulse[0]
    |=> port_data_oe_o && port_data_o[2:0] == $past(ack_lvl))
    else $error("type byte level field wrong");

  // Only a command write or the end of an acknowledge sequence may retire a level
  chk_isr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_hit && !ack_fall
    |=> (~st_r.in_service_latch & $past(st_r.in_service_latch)) == 16'h0000)
    else $error("in-service bit cleared without a command");

  chk_block_lower: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.in_service_latch[0][0] && st_r.top[0] == 3'h0 |-> !res_ok[0])
    else $error("request passed a higher in-service level");

endmodule : vectored_interrupt_pair

// file: hw/vectored_interrupt_pair_pkg.sv
package vectored_interrupt_pair_pkg;

  // Port decode inside the sixteen-port window, taken from address bits 3..1
  localparam logic [2:0] PORT_PRIMARY = 3'h0;
  localparam logic [2:0] PORT_SECONDARY = 3'h1;

  // Control word fields on the even port
  localparam int INIT_FLAG_BIT = 4;
  localparam int READ_SEL_BIT = 3;
  localparam int INTERVAL4_BIT = 2;
  localparam int CMD_LSB = 5;

  // Mode word fields, third word of the setup sequence on the odd port
  localparam int TWO_PULSE_BIT = 0;
  localparam int AUTO_EOS_BIT = 1;

  // Command codes in bits 7..5 of a non-setup even write
  localparam logic [2:0] CMD_NONSPECIFIC = 3'h1;
  localparam logic [2:0] CMD_SPECIFIC = 3'h3;
  localparam logic [2:0] CMD_SET_TOP = 3'h6;

  localparam logic [7:0] CALL_OPCODE = 8'hcd;
  localparam logic [2:0] TOP_LEVEL_AFTER_INIT = 3'h0;

  // Acknowledge pulse numbers
  localparam logic [1:0] PULSE_FIRST = 2'h1;
  localparam logic [1:0] PULSE_SECOND = 2'h2;
  localparam logic [1:0] PULSE_THIRD = 2'h3;

  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] FIELD3_RESET = 3'h0;
  localparam logic [1:0] COUNT_RESET = 2'h0;

  typedef enum logic [2:0] {
    SETUP_DONE = 3'b001,
    SETUP_ADDR = 3'b010,
    SETUP_MODE = 3'b100
  } setup_e;

endpackage : vectored_interrupt_pair_pkg

// file: verification/host_model.sv
module host_model (
  input wire logic clk_i,
  input wire logic [3:0] port_window_origin_i,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_i,
  output logic [7:0] addr_o,
  output logic [7:0] data_o,
  output logic rd_o,
  output logic wr_o,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    addr_o = 8'h00;
    data_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    ack_o = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : step

  // Strobes held past the device's two-stage input lag
  task automatic write(input logic [3:0] off, input logic [7:0] val);
    step(1);
    addr_o = {port_window_origin_i, off};
    data_o = val;
    wr_o = 1'b1;
    step(4);
    wr_o = 1'b0;
    data_o = ~val; // Released bus never repeats the last byte
    step(3);
  endtask : write

  task automatic read(input logic [7:0] a, output logic oe, output logic [7:0] d);
    step(1);
    addr_o = a;
    rd_o = 1'b1;
    step(5);
    oe = dev_oe_i;
    d = dev_data_i;
    rd_o = 1'b0;
    step(4);
  endtask : read

  task automatic ack(output logic oe, output logic [7:0] d);
    step(1);
    ack_o = 1'b1;
    step(5);
    oe = dev_oe_i;
    d = dev_data_i;
    ack_o = 1'b0;
    step(4);
  endtask : ack

  // Setup word, address high byte, mode, then an open mask
  task automatic init(input logic [3:0] even, input logic [7:0] w1, input logic [7:0] hi,
                      input logic [7:0] mode);
    write(even, w1);
    write(even + 4'h1, hi);
    write(even + 4'h1, mode);
    write(even + 4'h1, 8'h00);
  endtask : init

  task automatic ack_seq(input logic two, output logic [2:0] oe, output logic [23:0] d);
    oe = 3'h0;
    d = 24'h0;
    ack(oe[0], d[7:0]);
    ack(oe[1], d[15:8]);
    if (!two) ack(oe[2], d[23:16]);
  endtask : ack_seq
endmodule : host_model

// file: verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic two;
    logic iv4;
    logic [7:0] lines;
    logic [6:0] flags;
    logic [7:0] lo;
    logic [7:0] hi;
  } row_s;
  row_s rows [12];
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sw = 4'ha;
  logic [3:0] hbase = 4'ha;
  logic [7:0] lines = 8'h00;
  logic [6:0] flags = 7'h00;
  logic [7:0] addr;
  logic [7:0] dat;
  logic rd;
  logic wr;
  logic ack;
  logic [7:0] q;
  logic oe;
  logic irq;
  logic so;
  logic [2:0] sos;
  logic [23:0] sd;
  int miscompares = 0;
  int comparisons = 0;

  always #12.5 clk = ~clk;

  vectored_interrupt_pair u_dut (
    .clk_i(clk),
    .rst_i(rst),
    .setup_switch_bank_i(sw),
    .port_addr_i(addr),
    .port_data_i(dat),
    .port_rd_i(rd),
    .port_wr_i(wr),
    .acknowledge_pulse_i(ack),
    .vectored_line_i(lines),
    .timer_output_two_i(flags[0]),
    .serial_receive_ready_flag_i(flags[1]),
    .parallel_receive_ready_flag_i(flags[2]),
    .timer_output_three_i(flags[3]),
    .serial_transmit_ready_flag_i(flags[4]),
    .parallel_transmit_ready_flag_i(flags[5]),
    .timer_output_four_i(flags[6]),
    .port_data_o(q),
    .port_data_oe_o(oe),
    .int_req_o(irq)
  );

  host_model u_host (
    .clk_i(clk),
    .port_window_origin_i(hbase),
    .dev_data_i(q),
    .dev_oe_i(oe),
    .addr_o(addr),
    .data_o(dat),
    .rd_o(rd),
    .wr_o(wr),
    .ack_o(ack)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 20) begin
      @(posedge clk);
      #2;
      n++;
    end
    check({7'h0, irq}, {7'h0, lvl});
    if (irq !== lvl) results();
  endtask : wait_irq

  // Long enough for a request to cross sync and latch if it were let through
  task automatic idle_chk();
    repeat (8) @(posedge clk);
    #2;
    check({7'h0, irq}, 8'h00);
  endtask : idle_chk

  task automatic rd_chk(input logic [7:0] a, input logic o, input logic [7:0] e);
    u_host.read(a, so, sd[7:0]);
    check({7'h0, so}, {7'h0, o});
    if (o) check(sd[7:0], e);
  endtask : rd_chk

  task automatic acks_chk(input logic two, input logic [7:0] lo, input logic [7:0] hi);
    u_host.ack_seq(two, sos, sd);
    if (two) begin
      check({5'h0, sos}, 8'h02);
      check(sd[15:8], lo);
    end else begin
      check({5'h0, sos}, 8'h07);
      check(sd[7:0], vectored_interrupt_pair_pkg::CALL_OPCODE);
      check(sd[15:8], lo);
      check(sd[23:16], hi);
    end
  endtask : acks_chk

  initial begin
    rows[0] = '{1'b0, 1'b1, 8'h01, 7'h00, 8'ha0, 8'h12};
    rows[1] = '{1'b0, 1'b0, 8'h80, 7'h00, 8'hb8, 8'h12};
    rows[2] = '{1'b0, 1'b1, 8'h0c, 7'h00, 8'ha8, 8'h12};
    rows[3] = '{1'b1, 1'b0, 8'h08, 7'h00, 8'h13, 8'h00};
    rows[4] = '{1'b0, 1'b0, 8'h00, 7'h01, 8'h40, 8'h34};
    rows[5] = '{1'b1, 1'b0, 8'h02, 7'h00, 8'h33, 8'h00};
    rows[6] = '{1'b1, 1'b0, 8'h00, 7'h02, 8'h31, 8'h00};
    rows[7] = '{1'b1, 1'b0, 8'h00, 7'h04, 8'h32, 8'h00};
    rows[8] = '{1'b1, 1'b0, 8'h00, 7'h08, 8'h34, 8'h00};
    rows[9] = '{1'b1, 1'b0, 8'h00, 7'h10, 8'h35, 8'h00};
    rows[10] = '{1'b1, 1'b0, 8'h00, 7'h20, 8'h36, 8'h00};
    rows[11] = '{1'b0, 1'b1, 8'h20, 7'h40, 8'h78, 8'h34};
    repeat (4) @(posedge clk);
    #2;
    check({6'h0, oe, irq}, 8'h00);
    rst = 1'b0;
    u_host.init(4'h2, 8'h50, 8'h34, 8'h00);
    for (int i = 0; i < 12; i++) begin
      u_host.init(4'h0, {5'h16, rows[i].iv4, 2'h0}, 8'h12, {7'h0, rows[i].two});
      lines = rows[i].lines;
      flags = rows[i].flags;
      wait_irq(1'b1);
      acks_chk(rows[i].two, rows[i].lo, rows[i].hi);
      lines = 8'h00;
      flags = 7'h00;
      u_host.write(4'h0, 8'h20);
      u_host.write(4'h2, 8'h20);
      wait_irq(1'b0);
    end
    u_host.init(4'h0, 8'hb0, 8'h12, 8'h00);
    lines = 8'h08;
    wait_irq(1'b1);
    acks_chk(1'b0, 8'h98, 8'h12);
    idle_chk();
    lines = 8'h28;
    idle_chk();
    lines = 8'h29;
    wait_irq(1'b1);
    acks_chk(1'b0, 8'h80, 8'h12);
    u_host.write(4'h0, 8'h08);
    rd_chk(8'ha0, 1'b1, 8'h29);
    u_host.write(4'h0, 8'h09);
    rd_chk(8'ha0, 1'b1, 8'h09);
    u_host.write(4'h0, 8'h20);
    rd_chk(8'ha0, 1'b1, 8'h08);
    u_host.write(4'h0, 8'h63);
    rd_chk(8'ha0, 1'b1, 8'h00);
    lines = 8'h41;
    u_host.write(4'h0, 8'hc5);
    wait_irq(1'b1);
    acks_chk(1'b0, 8'hb0, 8'h12);
    lines = 8'h00;
    u_host.init(4'h0, 8'hb0, 8'h12, 8'h02);
    lines = 8'h10;
    wait_irq(1'b1);
    acks_chk(1'b0, 8'ha0, 8'h12);
    u_host.write(4'h0, 8'h09);
    rd_chk(8'ha0, 1'b1, 8'h00);
    wait_irq(1'b1);
    lines = 8'h00;
    u_host.write(4'h1, 8'ha5);
    u_host.write(4'h3, 8'h5a);
    hbase = 4'hb;
    u_host.write(4'h1, 8'hff);
    rd_chk(8'ha1, 1'b1, 8'ha5);
    rd_chk(8'ha3, 1'b1, 8'h5a);
    rd_chk(8'hb1, 1'b0, 8'h00);
    rd_chk(8'ha5, 1'b0, 8'h00);
    sw = 4'h3;
    hbase = 4'h3;
    rd_chk(8'h31, 1'b1, 8'ha5);
    u_host.ack_seq(1'b0, sos, sd);
    check({5'h0, sos}, 8'h00);
    lines = 8'h40;
    wait_irq(1'b1);
    rst = 1'b1;
    @(posedge clk);
    #2;
    check({6'h0, oe, irq}, 8'h00);
    rst = 1'b0;
    // Request still pending, but the input lag keeps the line low for two edges
    repeat (2) @(posedge clk);
    #2;
    check({6'h0, oe, irq}, 8'h00);
    results();
  end
endmodule : tb
